// File: logic/jtc_map.svh
// Constants of the config test access port: codes, widths, ID fields.
// Assumes inclusion by the package and the checker.
`ifndef JTC_MAP_SVH
`define JTC_MAP_SVH
`define JTC_IR_W 4
`define JTC_IR_CAPTURE 4'h1
`define JTC_OP_EXTEST 4'h0
`define JTC_OP_SAMPLE 4'h1
`define JTC_OP_IDCODE 4'h2
`define JTC_OP_CFG_WR 4'h4
`define JTC_OP_CFG_RD 4'h5
`define JTC_OP_CFG_SAVE 4'h6
`define JTC_OP_CFG_RESTORE 4'h7
`define JTC_OP_CLAMP 4'h8
`define JTC_OP_HIGHZ 4'h9
`define JTC_OP_BYPASS 4'hF
`define JTC_CFG_W 96
`define JTC_PATH_W 112
`define JTC_RSV_W 16
`define JTC_ID_W 32
`define JTC_MFR_W 11
`endif

// File: logic/jtc_pkg.sv
// Types of the config test access port.
// Assumes the map header sits beside it.
package jtc_pkg;
  `include "jtc_map.svh"
  // ==========================================================
  // TAP states
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
    ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UP_DR = 16'h0100,
    ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000,
    ST_UP_IR = 16'h8000
  } jtc_state_t;
  // ==========================================================
  // Request to the system side
  typedef struct packed {
    logic save;
    logic restore;
    logic cfg_load;
  } jtc_req_t;
endpackage

// File: logic/jtc_tap.sv
// TAP controller, instruction register and data registers.
// Assumes a TCLK link domain and a 10 MHz system domain.
`timescale 1ns/1ns
module jtc_tap #(
  parameter int BSR_W = 8,
  parameter logic [3:0] VERSION = 4'h0,
  parameter logic [15:0] PART_NUM = 16'h1234,  // Arbitrary value
  parameter logic [10:0] MFR_ID = 11'h155      // Arbitrary value
) (
  // System clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  // Test access port
  input wire logic I_TCLK,
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic I_TRSTN,
  output logic O_TDO,
  output logic O_TDO_OE,
  // Boundary pin cells
  input wire logic [BSR_W-1:0] I_PIN_IN,
  input wire logic [BSR_W-1:0] I_CORE_OUT,
  output logic [BSR_W-1:0] O_PIN_OUT,
  output logic O_PIN_HIGHZ,
  // Configuration side, system domain
  input wire logic [`JTC_CFG_W-1:0] I_CFG_RD,
  input wire logic I_NVM_BUSY,
  output jtc_pkg::jtc_req_t O_REQ,
  output logic [`JTC_CFG_W-1:0] O_CFG_WR,
  output logic O_TAP_READY
);
  import jtc_pkg::*;

  // ==========================================================
  // TAP state machine
  jtc_state_t st_r, st_nxt;
  always_comb begin
    case (st_r)
      ST_RESET: begin
        if (I_TMS) begin
          st_nxt = ST_RESET;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (I_TMS) begin
          st_nxt = ST_SEL_DR;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_SEL_DR: begin
        if (I_TMS) begin
          st_nxt = ST_SEL_IR;
        end else begin
          st_nxt = ST_CAP_DR;
        end
      end
      ST_CAP_DR: begin
        if (I_TMS) begin
          st_nxt = ST_EX1_DR;
        end else begin
          st_nxt = ST_SH_DR;
        end
      end
      ST_SH_DR: begin
        if (I_TMS) begin
          st_nxt = ST_EX1_DR;
        end else begin
          st_nxt = ST_SH_DR;
        end
      end
      ST_EX1_DR: begin
        if (I_TMS) begin
          st_nxt = ST_UP_DR;
        end else begin
          st_nxt = ST_PA_DR;
        end
      end
      ST_PA_DR: begin
        if (I_TMS) begin
          st_nxt = ST_EX2_DR;
        end else begin
          st_nxt = ST_PA_DR;
        end
      end
      ST_EX2_DR: begin
        if (I_TMS) begin
          st_nxt = ST_UP_DR;
        end else begin
          st_nxt = ST_SH_DR;
        end
      end
      ST_UP_DR: begin
        if (I_TMS) begin
          st_nxt = ST_SEL_DR;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_SEL_IR: begin
        if (I_TMS) begin
          st_nxt = ST_RESET;
        end else begin
          st_nxt = ST_CAP_IR;
        end
      end
      ST_CAP_IR: begin
        if (I_TMS) begin
          st_nxt = ST_EX1_IR;
        end else begin
          st_nxt = ST_SH_IR;
        end
      end
      ST_SH_IR: begin
        if (I_TMS) begin
          st_nxt = ST_EX1_IR;
        end else begin
          st_nxt = ST_SH_IR;
        end
      end
      ST_EX1_IR: begin
        if (I_TMS) begin
          st_nxt = ST_UP_IR;
        end else begin
          st_nxt = ST_PA_IR;
        end
      end
      ST_PA_IR: begin
        if (I_TMS) begin
          st_nxt = ST_EX2_IR;
        end else begin
          st_nxt = ST_PA_IR;
        end
      end
      ST_EX2_IR: begin
        if (I_TMS) begin
          st_nxt = ST_UP_IR;
        end else begin
          st_nxt = ST_SH_IR;
        end
      end
      ST_UP_IR: begin
        if (I_TMS) begin
          st_nxt = ST_SEL_DR;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_RESET;
      end
    endcase
  end

  // Tms-high walk ends in reset within five edges
  always_ff @(posedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Save/restore busy flag, synchronised into TCLK
  logic busy_s1_r, busy_s2_r;
  always_ff @(posedge I_TCLK) begin
    busy_s1_r <= I_NVM_BUSY;
    busy_s2_r <= busy_s1_r;
  end

  // ==========================================================
  // Instruction register
  logic [3:0] ir_sh_r, ir_r, ir_nxt;
  always_ff @(posedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) begin
      ir_sh_r <= `JTC_IR_CAPTURE;
    end else if (st_r == ST_CAP_IR) begin
      ir_sh_r <= `JTC_IR_CAPTURE;
    end else if (st_r == ST_SH_IR) begin
      ir_sh_r <= {I_TDI, ir_sh_r[3:1]};
    end
  end

  // Config codes 4 to 7, read included, refused while nonvolatile access runs
  always_comb begin
    ir_nxt = ir_sh_r;
    if (ir_sh_r[3:2] == 2'b01 && busy_s2_r) begin
      ir_nxt = `JTC_OP_BYPASS;
    end
  end

  always_ff @(negedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) begin
      ir_r <= `JTC_OP_IDCODE;
    end else if (st_r == ST_RESET) begin
      ir_r <= `JTC_OP_IDCODE;
    end else if (st_r == ST_UP_IR) begin
      ir_r <= ir_nxt;
    end
  end

  // ==========================================================
  // Decode
  logic sel_bsr, sel_id, sel_cfg, sel_byp;
  always_comb begin
    sel_bsr = (ir_r == `JTC_OP_EXTEST) || (ir_r == `JTC_OP_SAMPLE);
    sel_id = (ir_r == `JTC_OP_IDCODE);
    sel_cfg = (ir_r == `JTC_OP_CFG_WR) || (ir_r == `JTC_OP_CFG_RD);
    sel_byp = !(sel_bsr || sel_id || sel_cfg);
  end

  // ==========================================================
  // Data registers
  logic byp_r;
  logic [`JTC_ID_W-1:0] id_r;
  logic [BSR_W-1:0] bsr_r, bsr_up_r;
  logic [`JTC_PATH_W-1:0] cfg_r;
  logic [`JTC_CFG_W-1:0] cfg_rd_s1_r, cfg_rd_s2_r;
  logic [`JTC_ID_W-1:0] id_val;
  assign id_val = {VERSION, PART_NUM, MFR_ID, 1'b1};

  always_ff @(posedge I_TCLK) begin
    cfg_rd_s1_r <= I_CFG_RD;
    cfg_rd_s2_r <= cfg_rd_s1_r;
  end

  always_ff @(posedge I_TCLK) begin
    if (st_r == ST_CAP_DR && sel_byp) begin
      byp_r <= 1'b0;
    end else if (st_r == ST_SH_DR && sel_byp) begin
      byp_r <= I_TDI;
    end
  end

  always_ff @(posedge I_TCLK) begin
    if (st_r == ST_CAP_DR && sel_id) begin
      id_r <= id_val;
    end else if (st_r == ST_SH_DR && sel_id) begin
      id_r <= {I_TDI, id_r[`JTC_ID_W-1:1]};
    end
  end

  always_ff @(posedge I_TCLK) begin
    if (st_r == ST_CAP_DR && sel_bsr) begin
      bsr_r <= I_PIN_IN;
    end else if (st_r == ST_SH_DR && sel_bsr) begin
      bsr_r <= {I_TDI, bsr_r[BSR_W-1:1]};
    end
  end

  always_ff @(negedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) begin
      bsr_up_r <= '0;
    end else if (st_r == ST_UP_DR && sel_bsr) begin
      bsr_up_r <= bsr_r;
    end
  end

  // Bit 0 first in and out, reserved top reads zero
  always_ff @(posedge I_TCLK) begin
    if (st_r == ST_CAP_DR && sel_cfg) begin
      cfg_r <= {{`JTC_RSV_W{1'b0}}, cfg_rd_s2_r};
    end else if (st_r == ST_SH_DR && sel_cfg) begin
      cfg_r <= {I_TDI, cfg_r[`JTC_PATH_W-1:1]};
    end
  end

  // ==========================================================
  // TDO on falling edge
  logic tdo_mux;
  always_comb begin
    if (st_r == ST_SH_IR) begin
      tdo_mux = ir_sh_r[0];
    end else if (sel_id) begin
      tdo_mux = id_r[0];
    end else if (sel_bsr) begin
      tdo_mux = bsr_r[0];
    end else if (sel_cfg) begin
      tdo_mux = cfg_r[0];
    end else begin
      tdo_mux = byp_r;
    end
  end

  always_ff @(negedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) begin
      O_TDO <= 1'b0;
      O_TDO_OE <= 1'b0;
    end else begin
      O_TDO <= tdo_mux;
      O_TDO_OE <= (st_r == ST_SH_IR) || (st_r == ST_SH_DR);
    end
  end

  // ==========================================================
  // Pin cells; normal path outside test modes
  logic drive_bsr;
  always_comb begin
    drive_bsr = (ir_r == `JTC_OP_EXTEST) || (ir_r == `JTC_OP_CLAMP);
    O_PIN_HIGHZ = (ir_r == `JTC_OP_HIGHZ);
  end

  // One output cell per pin
  for (genvar g = 0; g < BSR_W; g++) begin : g_cell
    assign O_PIN_OUT[g] = drive_bsr ? bsr_up_r[g] : I_CORE_OUT[g];
  end

  // ==========================================================
  // Requests to system domain: toggle per event
  logic wr_tg_r, sv_tg_r, rs_tg_r, rst_seen_r;
  logic [`JTC_CFG_W-1:0] cfg_hold_r;
  always_ff @(negedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) begin
      wr_tg_r <= 1'b0;
      sv_tg_r <= 1'b0;
      rs_tg_r <= 1'b0;
      cfg_hold_r <= '0;
    end else begin
      if (st_r == ST_UP_DR && ir_r == `JTC_OP_CFG_WR) begin
        wr_tg_r <= !wr_tg_r;
        cfg_hold_r <= cfg_r[`JTC_CFG_W-1:0];
      end
      // Save and restore start at Update-IR
      if (st_r == ST_UP_IR && ir_nxt == `JTC_OP_CFG_SAVE) begin
        sv_tg_r <= !sv_tg_r;
      end
      if (st_r == ST_UP_IR && ir_nxt == `JTC_OP_CFG_RESTORE) begin
        rs_tg_r <= !rs_tg_r;
      end
    end
  end

  // Marks a completed TAP reset
  always_ff @(posedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) begin
      rst_seen_r <= 1'b1;
    end else if (st_r == ST_RESET) begin
      rst_seen_r <= 1'b1;
    end
  end

  logic [2:0] wr_s_r, sv_s_r, rs_s_r;
  logic [1:0] rdy_s_r;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      wr_s_r <= 3'h0;
      sv_s_r <= 3'h0;
      rs_s_r <= 3'h0;
      rdy_s_r <= 2'h0;
    end else begin
      wr_s_r <= {wr_s_r[1:0], wr_tg_r};
      sv_s_r <= {sv_s_r[1:0], sv_tg_r};
      rs_s_r <= {rs_s_r[1:0], rs_tg_r};
      rdy_s_r <= {rdy_s_r[0], rst_seen_r};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      O_REQ <= '0;
      O_CFG_WR <= '0;
      O_TAP_READY <= 1'b0;
    end else begin
      O_REQ.cfg_load <= wr_s_r[2] ^ wr_s_r[1];
      O_REQ.save <= sv_s_r[2] ^ sv_s_r[1];
      O_REQ.restore <= rs_s_r[2] ^ rs_s_r[1];
      O_TAP_READY <= rdy_s_r[1];
      if (wr_s_r[2] ^ wr_s_r[1]) begin
        O_CFG_WR <= cfg_hold_r;
      end
    end
  end
endmodule // jtc_tap

// File: tb/jtc_host.sv
// Host model of the test port: clock, mode, data in, test reset.
// Assumes the device answers on falling edges of the test clock.
`timescale 1ns/1ns
module jtc_host (
  // Host side drive
  output logic tclk,
  output logic tms,
  output logic tdi,
  output logic trstn,
  // Device answer
  input wire logic tdo,
  input wire logic tdo_oe
);
  logic q;
  initial {tclk, tms, tdi, trstn} = 4'h4;
  // ====
  // One test clock, stopped low between calls
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #5 q = tdo_oe ? tdo : ~q;
    tclk = 1'b1;
    #6 tclk = 1'b0;
    #1;
  endtask
  // ====
  // Reset to Run-Test-Idle
  task automatic reset(input logic hard);
    if (hard) begin
      trstn = 1'b0;
      #30 trstn = 1'b1;
    end
    repeat (5) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  // ====
  // Scan of n bits from Run-Test-Idle and back
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
      output logic [127:0] dout);
    dout = 128'h0;
    step(1'b1, 1'b0);
    if (ir) step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    step(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i]);
      dout[i] = q;
    end
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule // jtc_host

// File: tb/jtc_tap_props.sv
// Checker of the config test access port at its pins.
// Assumes the standard TAP state graph clocked by I_TCLK.
`timescale 1ns/1ns
`include "jtc_map.svh"
module jtc_tap_props
  import jtc_pkg::*;
(
  // Clocks and resets
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic I_TCLK,
  input wire logic I_TRSTN,
  // Watched signals
  input wire logic I_TMS,
  input wire logic I_TDI,
  input wire logic O_TDO,
  input wire logic O_TDO_OE,
  input wire logic O_PIN_HIGHZ,
  input wire logic O_TAP_READY,
  input wire jtc_pkg::jtc_req_t O_REQ
);
  // ====
  // Shadow of state and instruction
  localparam logic [63:0] NX0 = 64'h1BDD_BBA1_4664_4311;
  localparam logic [63:0] NX1 = 64'h2FEF_CC02_8785_5920;
  localparam logic [3:0] S_TLR = 4'h0, S_CDR = 4'h3, S_SDR = 4'h4;
  localparam logic [3:0] S_CIR = 4'hA, S_SIR = 4'hB, S_UIR = 4'hF;
  logic [3:0] st_r, sh_r, ir_r;
  always_ff @(posedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) st_r <= S_TLR;
    else st_r <= I_TMS ? NX1[{st_r, 2'h0} +: 4] : NX0[{st_r, 2'h0} +: 4];
  end
  always_ff @(posedge I_TCLK) begin
    if (st_r == S_SIR) sh_r <= {I_TDI, sh_r[3:1]};
  end
  always_ff @(negedge I_TCLK or negedge I_TRSTN) begin
    if (!I_TRSTN) ir_r <= `JTC_OP_IDCODE;
    else if (st_r == S_TLR) ir_r <= `JTC_OP_IDCODE;
    else if (st_r == S_UIR) ir_r <= sh_r;
  end
  // ====
  // Assertions
  chk_oe_shift: assert property (@(posedge I_TCLK) disable iff (!I_TRSTN)
    O_TDO_OE == (st_r == S_SDR || st_r == S_SIR)) else $error("tdo enable");
  chk_capir_bits: assert property (@(posedge I_TCLK) disable iff (!I_TRSTN)
    (st_r == S_SIR && $past(st_r) == S_CIR) |-> O_TDO ##1
    (st_r != S_SIR || !O_TDO)) else $error("ir capture");
  chk_id_lsb: assert property (@(posedge I_TCLK) disable iff (!I_TRSTN)
    (st_r == S_SDR && $past(st_r) == S_CDR && ir_r == `JTC_OP_IDCODE)
    |-> O_TDO) else $error("id bit 0");
  chk_bypass_flow: assert property (@(posedge I_TCLK) disable iff (!I_TRSTN)
    (st_r == S_SDR && $past(st_r) == S_SDR && ir_r[3])
    |-> O_TDO == $past(I_TDI)) else $error("bypass delay");
  chk_highz_pin: assert property (@(posedge I_TCLK) disable iff (!I_TRSTN)
    O_PIN_HIGHZ == (ir_r == `JTC_OP_HIGHZ)) else $error("highz");
  chk_tms_reset: assert property (@(posedge I_TCLK) disable iff (!I_TRSTN)
    I_TMS [*5] |=> !O_PIN_HIGHZ && !O_TDO_OE) else $error("tms reset");
  chk_req_single: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
    (O_REQ != 3'h0) |=> (O_REQ == 3'h0)) else $error("request width");
  chk_reset_quiet: assert property (@(posedge I_SYS_CLK)
    !I_RSTN |=> (O_REQ == 3'h0 && !O_TAP_READY)) else $error("reset");
  cov_upd_ir: cover property (@(posedge I_TCLK) st_r == S_UIR);
  cov_save: cover property (@(posedge I_SYS_CLK) O_REQ.save);
  cov_load: cover property (@(posedge I_SYS_CLK) O_REQ.cfg_load);
endmodule // jtc_tap_props
bind jtc_tap jtc_tap_props u_props (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN),
  .I_TCLK(I_TCLK), .I_TRSTN(I_TRSTN), .I_TMS(I_TMS), .I_TDI(I_TDI),
  .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE), .O_PIN_HIGHZ(O_PIN_HIGHZ),
  .O_TAP_READY(O_TAP_READY), .O_REQ(O_REQ));

// File: tb/test_jtag_tap_config_port.sv
// Testbench of the config test access port with a host model.
// Assumes the design package, host model and bound checker.
`timescale 1ns/1ns
module test_jtag_tap_config_port;
  import jtc_pkg::*;
  localparam logic [31:0] ID = 32'h0123_4567; // Arbitrary value
  logic clk = 1'b0, rstn = 1'b0, busy = 1'b0;
  logic [7:0] core = 8'h00, pin = 8'h00;
  logic [95:0] cfg_rd = 96'h0;
  logic [127:0] din, dout, exp_v;
  int mismatches = 0, comparisons = 0;
  wire tck, tms, tdi, trstn, tdo, oe, hz, rdy;
  wire [95:0] cfg_wr;
  wire [7:0] pout;
  jtc_req_t req;
  initial forever #50 clk = ~clk;
  always @(posedge clk) {core, pin} <= 16'($urandom);
  jtc_host host (.tclk(tck), .tms(tms), .tdi(tdi), .trstn(trstn), .tdo(tdo),
    .tdo_oe(oe));
  jtc_tap #(.VERSION(ID[31:28]), .PART_NUM(ID[27:12]), .MFR_ID(ID[11:1]))
    uut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_TCLK(tck), .I_TMS(tms),
    .I_TDI(tdi), .I_TRSTN(trstn), .O_TDO(tdo), .O_TDO_OE(oe), .I_PIN_IN(pin),
    .I_CORE_OUT(core), .O_PIN_OUT(pout), .O_PIN_HIGHZ(hz), .I_CFG_RD(cfg_rd),
    .I_NVM_BUSY(busy), .O_REQ(req), .O_CFG_WR(cfg_wr), .O_TAP_READY(rdy));
  // ====
  // Checks and report
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t value mismatch", $time);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wait_req(input logic [2:0] m);
    int i;
    for (i = 0; i < 20 && (3'(req) & m) == 3'h0; i++) @(negedge clk);
    if (i == 20) begin
      chk(128'h0, 128'h1);
      final_report();
    end
  endtask
  // ====
  // Data scan against the path model
  task automatic drscan(input int len);
    int n;
    logic [127:0] m;
    n = (len == 112) ? 112 : len + 8;
    din = {$urandom, $urandom, $urandom, $urandom};
    host.scan(1'b0, n, din, dout);
    m = (128'h1 << n) - 128'h1;
    if (len == 8) m[7:0] = 8'h00;
    exp_v = (din << len) | (len == 32 ? 128'(ID) : 128'h0);
    if (len == 112) exp_v = exp_v | 128'(cfg_rd);
    chk(dout & m, exp_v & m);
  endtask
  // ====
  // Main sequence
  initial begin
    void'($urandom(72792));
    cfg_rd = {$urandom, $urandom, $urandom};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    host.reset(1'b1);
    repeat (5) @(negedge clk);
    chk(128'(rdy), 128'h1);
    drscan(32);
    for (int c = 0; c < 16; c++) begin
      if (c == 3) continue;
      host.scan(1'b1, 4, 128'(c), dout);
      chk(128'(dout[3:0]), 128'h1);
      chk(128'(hz), 128'(c == 9));
      if (c inside {6, 7}) wait_req(c == 6 ? 3'h4 : 3'h2);
      drscan(c == 2 ? 32 : c < 2 ? 8 : c inside {4, 5} ? 112 : 1);
      if (c < 2) begin
        @(negedge clk);
        chk(128'(pout), 128'(c == 0 ? din[15:8] : core));
      end
      if (c == 4) begin
        wait_req(3'h1);
        chk(128'(cfg_wr), 128'(din[95:0]));
      end
      repeat (6) @(negedge clk);
    end
    @(posedge clk) busy <= 1'b1;
    repeat (4) @(posedge clk);
    host.scan(1'b1, 4, 128'h5, dout);
    drscan(1);
    @(posedge clk) busy <= 1'b0;
    host.step(1'b1, 1'b0);
    host.step(1'b0, 1'b0);
    repeat (3) host.step(1'b0, 1'b1);
    host.reset(1'b0);
    drscan(32);
    final_report();
  end
endmodule // test_jtag_tap_config_port
